// [usart_cfg_pkg.sv]
/*
  Constants, field layouts and types shared by the serial transceiver
  frame-format and baud block. Assumes an 8-bit register port.
*/
package usart_cfg_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] STATUS_A_ADDR = 8'hc0;
  localparam logic [7:0] CTRL_B_ADDR   = 8'hc1;
  localparam logic [7:0] CTRL_C_ADDR   = 8'hc2;
  localparam logic [7:0] DIV_LOW_ADDR  = 8'hc4;
  localparam logic [7:0] DIV_HIGH_ADDR = 8'hc5;
  localparam logic [7:0] DATA_ADDR     = 8'hc6;

  localparam logic [7:0] CTRL_C_RESET  = 8'h06;
  localparam logic [7:0] DIV_RESET     = 8'h00;

  // ****************************************
  // Field encodings
  // ****************************************
  localparam logic [1:0] MODE_ASYNC = 2'h0;
  localparam logic [1:0] MODE_SYNC  = 2'h1;
  localparam logic [1:0] MODE_SPI   = 2'h3;

  localparam logic [4:0] OS_NORMAL  = 5'h10;
  localparam logic [4:0] OS_DOUBLE  = 5'h08;
  localparam logic [3:0] SPI_BITS   = 4'h8;
  localparam logic [3:0] DEF_BITS   = 4'h8;
  localparam logic [3:0] MAX_BITS   = 4'h9;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // In the SPI mode size_low[1] is data order (1 = LSB first), size_low[0] is phase
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] parity;
    logic       stop2;
    logic [1:0] size_low;
    logic       polarity;
  } ctrl_c_t;

  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;

endpackage

// [usart_frame_format_and_baud_config.sv]
/*
  Serial transceiver core: frame format, baud generator, asynchronous,
  synchronous and master SPI transfer. Assumes a register master that keeps
  strobes one cycle long and a receive line already synchronous to CORE_CLK.
*/
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module usart_frame_format_and_baud_config
  import usart_cfg_pkg::*;
(
  input  wire logic     CORE_CLK,
  input  wire logic     RST_B,
  input  wire reg_req_t BUS_REQ,
  output logic [7:0]    RD_DATA,
  input  wire logic     RECEIVE_LINE,
  output logic          TRANSMIT_LINE,
  output logic          SERIAL_CLOCK_LINE,
  output logic          SERIAL_CLOCK_OE
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [3:0] char_bits(input logic [2:0] code);
    logic [3:0] n;
    n = DEF_BITS;
    if (!code[2]) n = 4'h5 + {2'h0, code[1:0]};
    else if (code == 3'h7) n = MAX_BITS;
    return n;
  endfunction

  function automatic logic [7:0] rev8(input logic [7:0] d);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) r[i] = d[7-i];
    return r;
  endfunction

  function automatic logic [12:0] build_frame(input logic [8:0] d, input logic [3:0] n,
                                              input logic [1:0] par);
    logic [12:0] f;
    logic        p;
    f    = '1;
    f[0] = 1'b0;
    p    = par[0];
    for (int i = 0; i < 9; i++) begin
      if (i < int'(n)) begin
        f[i+1] = d[i];
        p      = p ^ d[i];
      end
    end
    if (par[1]) f[n+4'h1] = p;
    return f;
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  ctrl_c_t     ctrl_c_reg;
  logic [7:0]  div_low_reg;
  logic [3:0]  div_high_reg;
  logic        rx_en_reg, tx_en_reg, size_high_reg, tx_bit8_reg, dbl_reg;
  logic [11:0] baud_cnt_reg;
  logic [4:0]  tx_os_reg, rx_os_reg;
  logic        sclk_reg, sclk_oe_reg, tx_line_reg, tx_busy_reg, tx_done_reg;
  logic [12:0] tx_shift_reg;
  logic [3:0]  tx_left_reg, spi_samples_reg;
  rx_state_t   rx_state_reg, rx_state_next;
  logic [3:0]  rx_cnt_reg, rx_cnt_next;
  logic [8:0]  rx_shift_reg, rx_shift_next, rx_data_reg, rx_data_next;
  logic        rx_par_reg, rx_par_next, rx_perr_reg, rx_perr_next, rx_line_d_reg;
  logic        rx_ready_reg, par_err_reg, par_err_next, frame_err_reg, frame_err_next;
  logic        rx_store;
  logic [7:0]  rd_data_reg;

  // ****************************************
  // Decode
  // ****************************************
  wire        wr_status = BUS_REQ.wr && BUS_REQ.addr == STATUS_A_ADDR;
  wire        wr_ctrl_b = BUS_REQ.wr && BUS_REQ.addr == CTRL_B_ADDR;
  wire        wr_ctrl_c = BUS_REQ.wr && BUS_REQ.addr == CTRL_C_ADDR;
  wire        wr_low    = BUS_REQ.wr && BUS_REQ.addr == DIV_LOW_ADDR;
  wire        wr_high   = BUS_REQ.wr && BUS_REQ.addr == DIV_HIGH_ADDR;
  wire        wr_data   = BUS_REQ.wr && BUS_REQ.addr == DATA_ADDR;
  wire        rd_data   = BUS_REQ.rd && BUS_REQ.addr == DATA_ADDR;

  wire        is_async  = ctrl_c_reg.mode != MODE_SYNC && ctrl_c_reg.mode != MODE_SPI;
  wire        is_spi    = ctrl_c_reg.mode == MODE_SPI;
  wire        spi_lsb   = ctrl_c_reg.size_low[1];
  wire        spi_phase = ctrl_c_reg.size_low[0];
  wire [3:0]  n_bits    = is_spi ? SPI_BITS : char_bits({size_high_reg, ctrl_c_reg.size_low});
  wire        par_on    = ctrl_c_reg.parity[1] && !is_spi;

  // ****************************************
  // Baud generator
  // ****************************************
  wire [11:0] divisor   = {div_high_reg, div_low_reg};
  wire        baud_tick = baud_cnt_reg == 12'h000;
  wire [11:0] baud_cnt_next = wr_low    ? {div_high_reg, BUS_REQ.wdata} :
                              baud_tick ? divisor : baud_cnt_reg - 12'h001;
  wire [4:0]  os_len    = dbl_reg ? OS_DOUBLE : OS_NORMAL;
  wire        tx_bit_tick = baud_tick && tx_os_reg == 5'h00;

  // Clock only runs in SPI while a byte moves, so it parks at its idle level
  wire        spi_stop  = spi_samples_reg == SPI_BITS && sclk_reg == ctrl_c_reg.polarity;
  wire        sclk_run  = (ctrl_c_reg.mode == MODE_SYNC) ||
                          (is_spi && tx_busy_reg && !spi_stop);
  wire        rise_edge = baud_tick && sclk_run && !sclk_reg;
  wire        fall_edge = baud_tick && sclk_run && sclk_reg;
  wire        lead_edge = ctrl_c_reg.polarity ? fall_edge : rise_edge;
  wire        trail_edge = ctrl_c_reg.polarity ? rise_edge : fall_edge;
  wire        spi_early = is_spi && !spi_phase;
  wire        change_edge = spi_early ? trail_edge : lead_edge;
  wire        sample_edge = spi_early ? lead_edge : trail_edge;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      baud_cnt_reg <= 12'h000;
      tx_os_reg    <= 5'h00;
      sclk_reg     <= 1'b0;
      sclk_oe_reg  <= 1'b0;
    end else begin
      baud_cnt_reg <= baud_cnt_next;
      if (baud_tick) tx_os_reg <= (tx_os_reg == 5'h00) ? os_len - 5'h01 : tx_os_reg - 5'h01;
      if (!sclk_run) sclk_reg <= ctrl_c_reg.polarity;
      else if (baud_tick) sclk_reg <= !sclk_reg;
      sclk_oe_reg  <= !is_async;
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      ctrl_c_reg    <= CTRL_C_RESET;
      div_low_reg   <= DIV_RESET;
      div_high_reg  <= '0;
      rx_en_reg     <= 1'b0;
      tx_en_reg     <= 1'b0;
      size_high_reg <= 1'b0;
      tx_bit8_reg   <= 1'b0;
      dbl_reg       <= 1'b0;
    end else begin
      if (wr_ctrl_c) ctrl_c_reg <= BUS_REQ.wdata;
      if (wr_low)    div_low_reg <= BUS_REQ.wdata;
      if (wr_high)   div_high_reg <= BUS_REQ.wdata[3:0];
      if (wr_status) dbl_reg <= BUS_REQ.wdata[1];
      if (wr_ctrl_b) begin
        rx_en_reg     <= BUS_REQ.wdata[4];
        tx_en_reg     <= BUS_REQ.wdata[3];
        size_high_reg <= BUS_REQ.wdata[2];
        tx_bit8_reg   <= BUS_REQ.wdata[0];
      end
    end
  end

  wire [7:0] status_val = {rx_ready_reg, tx_done_reg, !tx_busy_reg, frame_err_reg,
                           1'b0, par_err_reg, dbl_reg, 1'b0};
  wire [7:0] ctrl_b_val = {3'h0, rx_en_reg, tx_en_reg, size_high_reg,
                           rx_data_reg[8], tx_bit8_reg};
  wire [7:0] rx_byte    = rx_data_reg[7:0];
  wire [7:0] read_mux   = (BUS_REQ.addr == STATUS_A_ADDR) ? status_val :
                          (BUS_REQ.addr == CTRL_B_ADDR)   ? ctrl_b_val :
                          (BUS_REQ.addr == CTRL_C_ADDR)   ? ctrl_c_reg :
                          (BUS_REQ.addr == DIV_LOW_ADDR)  ? div_low_reg :
                          (BUS_REQ.addr == DIV_HIGH_ADDR) ? {4'h0, div_high_reg} :
                          (BUS_REQ.addr == DATA_ADDR)     ? rx_byte : 8'h00;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) rd_data_reg <= 8'h00;
    else        rd_data_reg <= BUS_REQ.rd ? read_mux : 8'h00;
  end

  // ****************************************
  // Transmitter
  // ****************************************
  // No holding buffer: a data write while busy is dropped
  wire        tx_start  = wr_data && tx_en_reg && !tx_busy_reg;
  wire [8:0]  tx_data9  = {tx_bit8_reg, BUS_REQ.wdata};
  wire [7:0]  spi_bits  = spi_lsb ? BUS_REQ.wdata : rev8(BUS_REQ.wdata);
  wire [12:0] tx_frame  = build_frame(tx_data9, n_bits, {par_on, ctrl_c_reg.parity[0]});
  wire [3:0]  tx_len    = 4'h2 + n_bits + {3'h0, par_on} + {3'h0, ctrl_c_reg.stop2};
  wire        tx_step   = is_async ? tx_bit_tick : change_edge;
  wire        spi_end   = is_spi && tx_busy_reg && baud_tick && spi_stop;
  wire        usart_end = !is_spi && tx_busy_reg && tx_step && tx_left_reg == 4'h0;
  wire        tx_clear  = wr_status && BUS_REQ.wdata[6];
  // Bits above the character size must not leak into the expected parity
  wire        tx_par_expect = (^(tx_data9 & ~(9'h1ff << n_bits))) ^
                              ctrl_c_reg.parity[0];

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      tx_line_reg  <= 1'b1;
      tx_shift_reg <= '1;
      tx_left_reg  <= 4'h0;
      tx_busy_reg  <= 1'b0;
    end else if (tx_start) begin
      tx_busy_reg  <= 1'b1;
      tx_left_reg  <= tx_len;
      if (!is_spi) tx_shift_reg <= tx_frame;
      else if (spi_phase) tx_shift_reg <= {5'h1f, spi_bits};
      else begin
        // Phase 0 needs the first bit on the line before the first edge
        tx_line_reg  <= spi_bits[0];
        tx_shift_reg <= {6'h3f, spi_bits[7:1]};
      end
    end else if (spi_end || usart_end) begin
      tx_busy_reg  <= 1'b0;
    end else if (tx_busy_reg && tx_step) begin
      tx_line_reg  <= tx_shift_reg[0];
      tx_shift_reg <= {1'b1, tx_shift_reg[12:1]};
      tx_left_reg  <= tx_left_reg - 4'h1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      tx_done_reg     <= 1'b0;
      spi_samples_reg <= 4'h0;
    end else begin
      // Completion beats a same-cycle write-one clear
      if (spi_end || usart_end) tx_done_reg <= 1'b1;
      else if (tx_clear)        tx_done_reg <= 1'b0;
      if (tx_start) spi_samples_reg <= 4'h0;
      else if (is_spi && sample_edge) spi_samples_reg <= spi_samples_reg + 4'h1;
    end
  end

  // ****************************************
  // Receiver
  // ****************************************
  wire       rx_fall   = rx_line_d_reg && !RECEIVE_LINE;
  wire       rx_strobe = is_async ? (baud_tick && rx_os_reg == 5'h00 && rx_state_reg != RX_IDLE)
                                  : sample_edge;
  wire [8:0] rx_shift_in = {RECEIVE_LINE, rx_shift_reg[8:1]};
  wire       async_go  = is_async && rx_en_reg && rx_state_reg == RX_IDLE && rx_fall;
  wire [3:0] last_bit  = n_bits - 4'h1;

  always_comb begin
    rx_state_next  = rx_state_reg;
    rx_cnt_next    = rx_cnt_reg;
    rx_shift_next  = rx_shift_reg;
    rx_par_next    = rx_par_reg;
    rx_perr_next   = rx_perr_reg;
    rx_data_next   = rx_data_reg;
    par_err_next   = par_err_reg;
    frame_err_next = frame_err_reg;
    rx_store       = 1'b0;
    unique case (rx_state_reg)
      RX_IDLE: begin
        rx_cnt_next  = 4'h0;
        rx_par_next  = 1'b0;
        rx_perr_next = 1'b0;
        if (async_go) rx_state_next = RX_START;
        else if (is_spi && tx_start && rx_en_reg) rx_state_next = RX_DATA;
        else if (!is_async && !is_spi && rx_en_reg && sample_edge && !RECEIVE_LINE)
          rx_state_next = RX_DATA;
      end
      RX_START: begin
        if (rx_strobe) rx_state_next = RECEIVE_LINE ? RX_IDLE : RX_DATA;
      end
      RX_DATA: begin
        if (rx_strobe) begin
          rx_shift_next = rx_shift_in;
          rx_par_next   = rx_par_reg ^ RECEIVE_LINE;
          rx_cnt_next   = rx_cnt_reg + 4'h1;
          if (rx_cnt_reg == last_bit) begin
            if (is_spi) begin
              rx_store      = 1'b1;
              rx_data_next  = {1'b0, spi_lsb ? rx_shift_in[8:1] : rev8(rx_shift_in[8:1])};
              rx_state_next = RX_IDLE;
            end else begin
              rx_state_next = par_on ? RX_PARITY : RX_STOP;
            end
          end
        end
      end
      RX_PARITY: begin
        if (rx_strobe) begin
          rx_perr_next  = (rx_par_reg ^ RECEIVE_LINE) != ctrl_c_reg.parity[0];
          rx_state_next = RX_STOP;
        end
      end
      RX_STOP: begin
        // Only the first stop bit is looked at
        if (rx_strobe) begin
          rx_store       = 1'b1;
          rx_data_next   = rx_shift_reg >> (MAX_BITS - n_bits);
          par_err_next   = rx_perr_reg;
          frame_err_next = !RECEIVE_LINE;
          rx_state_next  = RX_IDLE;
        end
      end
    endcase
    if (!rx_en_reg) rx_state_next = RX_IDLE;
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      rx_state_reg  <= RX_IDLE;
      rx_cnt_reg    <= 4'h0;
      rx_shift_reg  <= '0;
      rx_par_reg    <= 1'b0;
      rx_perr_reg   <= 1'b0;
      rx_data_reg   <= '0;
      par_err_reg   <= 1'b0;
      frame_err_reg <= 1'b0;
      rx_ready_reg  <= 1'b0;
      rx_line_d_reg <= 1'b1;
      rx_os_reg     <= 5'h00;
    end else begin
      rx_state_reg  <= rx_state_next;
      rx_cnt_reg    <= rx_cnt_next;
      rx_shift_reg  <= rx_shift_next;
      rx_par_reg    <= rx_par_next;
      rx_perr_reg   <= rx_perr_next;
      rx_data_reg   <= rx_data_next;
      par_err_reg   <= par_err_next;
      frame_err_reg <= frame_err_next;
      rx_line_d_reg <= RECEIVE_LINE;
      // New character beats a same-cycle read
      if (rx_store) rx_ready_reg <= 1'b1;
      else if (rd_data || !rx_en_reg) rx_ready_reg <= 1'b0;
      if (async_go) rx_os_reg <= os_len >> 1;
      else if (baud_tick) rx_os_reg <= (rx_os_reg == 5'h00) ? os_len - 5'h01 : rx_os_reg - 5'h01;
    end
  end

  assign RD_DATA           = rd_data_reg;
  assign TRANSMIT_LINE     = tx_line_reg;
  assign SERIAL_CLOCK_LINE = sclk_reg;
  assign SERIAL_CLOCK_OE   = sclk_oe_reg;

  // ****************************************
  // Checks
  // ****************************************
  property p_reload;
    @(posedge CORE_CLK) disable iff (!RST_B)
      wr_low |=> baud_cnt_reg == {div_high_reg, div_low_reg};
  endproperty
  a_reload: assert property (p_reload) else $error("prescaler not reloaded");

  property p_period;
    @(posedge CORE_CLK) disable iff (!RST_B)
      (baud_tick && !wr_low && !wr_high) ##1 !wr_low [*2] |->
        baud_cnt_reg == (($past(divisor, 2) == 12'h000) ? 12'h000 : $past(divisor, 2) - 12'h001);
  endproperty
  a_period: assert property (p_period) else $error("prescaler count wrong");

  property p_high_zero;
    @(posedge CORE_CLK) disable iff (!RST_B)
      (BUS_REQ.rd && BUS_REQ.addr == DIV_HIGH_ADDR) |=> RD_DATA[7:4] == 4'h0;
  endproperty
  a_high_zero: assert property (p_high_zero) else $error("reserved divisor bits nonzero");

  property p_tx_parity;
    @(posedge CORE_CLK) disable iff (!RST_B)
      (tx_start && !is_spi && par_on) |=>
        tx_shift_reg[$past(n_bits) + 4'h1] == $past(tx_par_expect);
  endproperty
  a_tx_parity: assert property (p_tx_parity) else $error("parity bit wrong");

  property p_stop_len;
    @(posedge CORE_CLK) disable iff (!RST_B)
      (tx_start && !is_spi) |=> tx_left_reg == $past(tx_len) && tx_busy_reg;
  endproperty
  a_stop_len: assert property (p_stop_len) else $error("frame length wrong");

  property p_fast_clock;
    @(posedge CORE_CLK) disable iff (!RST_B)
      (sclk_run && divisor == 12'h000 && baud_cnt_reg == 12'h000 && !wr_low && !wr_high) |=>
        sclk_reg != $past(sclk_reg);
  endproperty
  a_fast_clock: assert property (p_fast_clock) else $error("clock not at half rate");

  property p_sync_change;
    @(posedge CORE_CLK) disable iff (!RST_B)
      (!is_async && $changed(tx_line_reg) && !$past(tx_start)) |-> $past(change_edge);
  endproperty
  a_sync_change: assert property (p_sync_change) else $error("data moved off edge");

  property p_rx_parity;
    @(posedge CORE_CLK) disable iff (!RST_B)
      (rx_state_reg == RX_STOP && rx_strobe && rx_en_reg) |=> par_err_reg == $past(rx_perr_reg) &&
        rx_ready_reg;
  endproperty
  a_rx_parity: assert property (p_rx_parity) else $error("parity flag wrong");

  property p_spi_done;
    @(posedge CORE_CLK) disable iff (!RST_B)
      spi_end |=> !tx_busy_reg && tx_done_reg && sclk_reg == ctrl_c_reg.polarity;
  endproperty
  a_spi_done: assert property (p_spi_done) else $error("spi byte end wrong");

endmodule // usart_frame_format_and_baud_config

// [usart_peer.sv]
/*
  Remote serial peer: sends and samples asynchronous frames.
  Assumes the bench clock and an idle-high line.
*/
`timescale 1ns/1ps
module usart_peer (
  input  wire logic clk,
  input  wire logic tx_in,
  output logic      rx_out
);
  // ****************************************
  // Frame tasks
  // ****************************************
  time t_start;
  initial rx_out = 1'b1;
  // LSB first, back to idle high after the last bit
  task automatic send(input logic [15:0] bits, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      @(posedge clk) rx_out <= bits[i];
      repeat (per - 1) @(posedge clk);
    end
    @(posedge clk) rx_out <= 1'b1;
  endtask
  // Mid-bit sampling; a missing start still samples the idle line after 20000 cycles
  task automatic grab(input int n, input int per, output logic [15:0] bits);
    int k;
    bits = '0;
    k = 0;
    while (tx_in !== 1'b0 && k < 20000) begin
      @(posedge clk);
      k++;
    end
    t_start = $time;
    repeat (per / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = tx_in;
      repeat (per) @(posedge clk);
    end
  endtask
endmodule // usart_peer

// [tb_usart_frame_format_and_baud_config.sv]
/*
  Self-checking bench for the frame format and baud block.
  Assumes the peer model and the shared package.
*/
`timescale 1ns/1ps
module tb_usart_frame_format_and_baud_config
  import usart_cfg_pkg::*;
;
  // ****************************************
  // Harness
  // ****************************************
  logic       CORE_CLK;
  logic       RST_B;
  reg_req_t   bus;
  logic [7:0] rd_data;
  logic       tx_line;
  logic       rx_line;
  logic       sclk;
  logic       sclk_oe;
  int         mismatches;
  int         checks;
  logic [2:0] sz [5] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h3};
  logic [1:0] pm [5] = '{2'h0, 2'h3, 2'h2, 2'h2, 2'h3};
  logic       s2 [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  logic       ds [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
  logic [7:0] dv [5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h01};
  logic [8:0] dt [5] = '{9'h013, 9'h02d, 9'h055, 9'h1a5, 9'h0a5};

  usart_frame_format_and_baud_config dut (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
    .BUS_REQ(bus), .RD_DATA(rd_data), .RECEIVE_LINE(rx_line),
    .TRANSMIT_LINE(tx_line), .SERIAL_CLOCK_LINE(sclk), .SERIAL_CLOCK_OE(sclk_oe));
  usart_peer peer (.clk(CORE_CLK), .tx_in(tx_line), .rx_out(rx_line));

  initial begin
    CORE_CLK = 1'b0;
    forever #50 CORE_CLK = ~CORE_CLK;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CORE_CLK) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge CORE_CLK) bus.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CORE_CLK) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge CORE_CLK) bus.rd <= 1'b0;
    #1 d = rd_data;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(what, d, exp);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_regs();
    rd_chk("div low", DIV_LOW_ADDR, DIV_RESET);
    rd_chk("div high", DIV_HIGH_ADDR, DIV_RESET);
    rd_chk("ctrl c", CTRL_C_ADDR, CTRL_C_RESET);
    rd_chk("unmapped", 8'hc7, 8'h00);
    wr(DIV_HIGH_ADDR, 8'hff);
    rd_chk("div high ro", DIV_HIGH_ADDR, 8'h0f);
    wr(DIV_LOW_ADDR, 8'h5a);
    rd_chk("div low rw", DIV_LOW_ADDR, 8'h5a);
    $display("test_regs done");
  endtask
  // Divisor only touched while idle, high byte before low
  task automatic setup(input int i);
    wr(STATUS_A_ADDR, {6'h10, ds[i], 1'b0});
    wr(DIV_HIGH_ADDR, 8'h00);
    wr(DIV_LOW_ADDR, dv[i]);
    wr(CTRL_C_ADDR, {MODE_ASYNC, pm[i], s2[i], sz[i][1:0], 1'b0});
    wr(CTRL_B_ADDR, {3'h0, 2'h3, sz[i][2], 1'b0, dt[i][8]});
  endtask
  task automatic test_tx();
    logic [15:0] got;
    logic [7:0]  st;
    logic [8:0]  m;
    int          n, p, per, k, tot;
    for (int i = 0; i < 5; i++) begin
      setup(i);
      check("clk oe async", sclk_oe, 1'b0);
      n = (sz[i] == 3'h7) ? 9 : sz[i] + 5;
      p = pm[i][1];
      m = (9'h1 << n) - 9'h1;
      per = (dv[i] + 1) * (ds[i] ? 8 : 16);
      wr(DATA_ADDR, dt[i][7:0]);
      peer.grab(n + p + 2, per, got);
      check("tx start", got[0], 1'b0);
      check("tx data", (got >> 1) & 16'(m), 16'(dt[i] & m));
      if (p == 1) check("tx parity", got[n + 1], ^(dt[i] & m) ^ pm[i][0]);
      check("tx stop", got[n + p + 1], 1'b1);
      k = 0;
      st = 8'h00;
      while (st[6] !== 1'b1 && k < 3000) begin
        rd(STATUS_A_ADDR, st);
        k++;
      end
      tot = int'(($time - peer.t_start) / 100) / per;
      check("frame bits", 16'(tot), 16'(n + p + 2 + s2[i]));
    end
    $display("test_tx done");
  endtask
  // Two stops selected, one sent: no frame error
  task automatic test_rx();
    logic [7:0] st;
    logic [7:0] d;
    for (int j = 0; j < 3; j++) begin
      peer.send({5'h0, j != 2, j != 1, 8'ha5, 1'b0}, 11, 16);
      rd(STATUS_A_ADDR, st);
      check("rx ready", st[7], 1'b1);
      check("parity err", st[2], j == 1);
      check("frame err", st[4], j == 2);
      rd(DATA_ADDR, d);
      check("rx data", d, 8'ha5);
    end
    $display("test_rx done");
  endtask
  task automatic test_sync();
    int   last;
    logic pv;
    logic tv;
    for (int pol = 0; pol < 2; pol++) begin
      wr(STATUS_A_ADDR, 8'h40);
      wr(DIV_LOW_ADDR, 8'h02);
      wr(CTRL_C_ADDR, {MODE_SYNC, 2'h0, 1'b0, 2'h3, pol[0]});
      wr(DATA_ADDR, 8'h96);
      #1 tv = tx_line;
      pv = sclk;
      last = -1;
      for (int k = 0; k < 200; k++) begin
        @(posedge CORE_CLK) #1;
        if (sclk !== pv && last >= 0) check("sclk half", 16'(k - last), 16'd3);
        if (sclk !== pv) last = k;
        if (tx_line !== tv) check("tx edge", sclk, !pol[0]);
        pv = sclk;
        tv = tx_line;
      end
      check("clk oe", sclk_oe, 1'b1);
    end
    $display("test_sync done");
  endtask
  // Toggle every core cycle means half the core clock
  task automatic test_spi();
    logic       pv;
    logic       lsb;
    logic [7:0] got;
    int         e, first, lastk;
    wr(DIV_LOW_ADDR, 8'h00);
    for (int m = 0; m < 4; m++) begin
      lsb = m[1] ^ m[0];
      wr(CTRL_C_ADDR, {MODE_SPI, 2'h0, 1'b0, lsb, m[0], m[1]});
      repeat (4) @(posedge CORE_CLK);
      pv = m[1];
      e = 0;
      got = 8'h00;
      wr(DATA_ADDR, 8'hb1);
      for (int k = 0; k < 40; k++) begin
        #1;
        if (sclk !== pv) begin
          e++;
          if (e == 1) first = k;
          lastk = k;
          if (e[0] != m[0]) got = lsb ? {tx_line, got[7:1]} : {got[6:0], tx_line};
        end
        pv = sclk;
        @(posedge CORE_CLK);
      end
      check("spi edges", 16'(e), 16'd16);
      check("spi rate", 16'(lastk - first), 16'd15);
      check("spi idle", sclk, m[1]);
      check("spi data", got, 8'hb1);
      check("spi master", sclk_oe, 1'b1);
      rd_chk("spi rx", DATA_ADDR, 8'hff);
    end
    $display("test_spi done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #(100 * 50000);
    mismatches++;
    $display("watchdog expired");
    print_verdict();
  end
  initial begin
    bus = '0;
    RST_B = 1'b0;
    mismatches = 0;
    checks = 0;
    repeat (20) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    test_regs();
    test_tx();
    test_rx();
    test_sync();
    test_spi();
    print_verdict();
  end
endmodule // tb_usart_frame_format_and_baud_config
